// ===== inc/apsg_pkg.sv
// Types of the auxiliary pin and SDA GPIO block.
// Assumes apsg_regs.svh for widths; holds no logic.
package apsg_pkg;

	typedef enum logic [3:0]
	{
		SEL_OFF = 4'h0,
		SEL_RSV = 4'h1,
		SEL_HS_IRQ = 4'h2,
		SEL_GPI = 4'h3,
		SEL_GPO = 4'h4,
		SEL_DMIC_A = 4'h5,
		SEL_DMIC_B = 4'h6,
		SEL_DMIC_C = 4'h7,
		SEL_BCLK = 4'h8,
		SEL_HS_BTN = 4'h9,
		SEL_ALL = 4'hA,
		SEL_SC_AGC = 4'hB,
		SEL_HS_BTN_SC = 4'hC,
		SEL_SC = 4'hD,
		SEL_AGC = 4'hE,
		SEL_BTN = 4'hF
	} apsg_sel_t;

	typedef enum logic [1:0]
	{
		SDA_NONE = 2'h0,
		SDA_GPI = 2'h1,
		SDA_GPO = 2'h2,
		SDA_RSV = 2'h3
	} apsg_sda_t;

	typedef enum logic [1:0]
	{
		PST_IDLE = 2'b00,
		PST_HIGH = 2'b01,
		PST_LOW = 2'b10
	} apsg_pst_t;

endpackage

// ===== inc/apsg_regs.svh
// Register map, field positions, reset values and timing figures of the auxiliary pin and SDA GPIO block.
// Assumes a 100 MHz core clock and byte-wide registers on the codec's internal register port.
`ifndef APSG_REGS_SVH
`define APSG_REGS_SVH

`define APSG_ADDR_W 7
`define APSG_ADDR_AUX2 7'h63
`define APSG_ADDR_EXTA 7'h64
`define APSG_DATA_W 8

`define APSG_SEL_MSB 7
`define APSG_SEL_LSB 4
`define APSG_SEL_W 4
`define APSG_GPO_BIT 3
`define APSG_GPI_BIT 2
`define APSG_RPT_BIT 1
`define APSG_RSV_BIT 0

`define APSG_SDA_MSB 7
`define APSG_SDA_LSB 6
`define APSG_SDA_W 2
`define APSG_SDA_OUT_BIT 5
`define APSG_SDA_IN_BIT 4

`define APSG_SEL_RST 4'h0
`define APSG_SDA_RST 2'h0
`define APSG_BIT_RST 1'h0
`define APSG_RDATA_RST 8'h00

`define APSG_NPIN 3
`define APSG_PIN_AUX 0
`define APSG_PIN_SDA 1
`define APSG_PIN_SEL 2
`define APSG_SYNC_W 3

`define APSG_CLK_KHZ 100000
`define APSG_PULSE_US 2000
`define APSG_HS_PULSE_US 1750
`define APSG_CNT_W 18

`endif

// ===== logic/apsg_ctrl.sv
// Control of the second auxiliary pin and of SDA used as a general-purpose pin.
// Assumes a byte register port on mclk_i, interrupt sources and serial clocks on mclk_i, pins asynchronous.
`timescale 1ns/10ps
`include "apsg_regs.svh"

// Notes on behaviour
// - The four-bit selector resets to zero, leaving the pin disabled, and code 0001 is reserved.
// - Code 0011 makes the pin a general input and code 0100 drives it from the stored output bit.
// - Codes 0101 to 0111 take microphone data from the pin on both edges of the modulator clock.
// - Code 1000 gives the pin to the serial bit clock, its direction following master or slave setup.
// - Code 0010 drives the headset-detect interrupt high on the pin for about 1.75 ms.
// - Code 1001 drives the OR of the headset and button interrupts.
// - Code 1010 drives the OR of all four sources and code 1011 the OR of short circuit and noise.
// - Code 1101 drives the short-circuit interrupt alone, while 1100 and 1111 are read as best guessed.
// - Bit 3 of the auxiliary register, zero after reset, sets the level driven in output mode.
// - Bit 2 of the auxiliary register reads the level on the pin while it is a general input.
// - Bit 1 picks one pulse of about 2 ms (1.75 ms under code 0010) per event, or pulses repeating until the flags are read.
// - Bits 7 and 6 of the second register set SDA unused, input or output, with 11 reserved.
// - Bit 5 sets the SDA output level, where one only releases the open-drain pin.
// - The SDA controls act only while the bus select input is high, that is in SPI mode.
// - Bit 4 of the second register reads the SDA level while SDA is a general input in SPI mode.
module apsg_ctrl
#(
	parameter int unsigned PULSE_CYC = `APSG_PULSE_US * (`APSG_CLK_KHZ / 1000),
	parameter int unsigned HS_PULSE_CYC = `APSG_HS_PULSE_US * (`APSG_CLK_KHZ / 1000)
)
(
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic [`APSG_ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [`APSG_DATA_W-1:0] reg_wdata_i,
	output logic [`APSG_DATA_W-1:0] reg_rdata_o,
	input wire logic spi_mode_i,
	input wire logic irq_headset_i,
	input wire logic irq_button_i,
	input wire logic irq_short_i,
	input wire logic irq_agc_i,
	input wire logic irq_flags_read_i,
	input wire logic dmic_clk_i,
	input wire logic bclk_master_i,
	input wire logic bclk_out_i,
	output logic bclk_in_o,
	output logic dmic_data_o,
	output logic dmic_valid_o,
	input wire logic aux_pin_two_in_i,
	output logic aux_pin_two_out_o,
	output logic aux_pin_two_oe_o,
	input wire logic sda_in_i,
	output logic sda_out_o,
	output logic sda_oe_o
);
	import apsg_pkg::*;

	logic [`APSG_NPIN-1:0] pin_raw;
	logic [`APSG_NPIN-1:0] pin_filt;
	apsg_sel_t sel_q, sel_d;
	logic gpo_q, gpo_d;
	logic rpt_q, rpt_d;
	logic rsv_q, rsv_d;
	apsg_sda_t sda_mode_q, sda_mode_d;
	logic sda_val_q, sda_val_d;
	logic irq_now;
	logic irq_prev_q;
	logic irq_trig;
	logic pulse;
	logic [`APSG_CNT_W-1:0] pulse_len;
	logic aux_gpi;
	logic sda_gpi;
	logic sda_drive_low;
	logic aux_out_q, aux_out_d;
	logic aux_oe_q, aux_oe_d;
	logic sda_oe_q, sda_oe_d;
	logic bclk_in_q, bclk_in_d;
	logic dmic_clk_q;
	logic dmic_data_q, dmic_data_d;
	logic dmic_valid_q, dmic_valid_d;
	logic [`APSG_DATA_W-1:0] rdata_q, rdata_d;

	assign pin_raw = {spi_mode_i, sda_in_i, aux_pin_two_in_i};

	// Three-stage synchronisers; a new level is taken only when the last two stages agree.
	genvar gi;
	generate
		for (gi = 0; gi < `APSG_NPIN; gi = gi + 1)
		begin : g_sync
			logic [`APSG_SYNC_W-1:0] sync_q, sync_d;
			logic filt_q, filt_d;
			always_comb
			begin
				sync_d = {sync_q[`APSG_SYNC_W-2:0], pin_raw[gi]};
				filt_d = (sync_q[`APSG_SYNC_W-2] == sync_q[`APSG_SYNC_W-1]) ? sync_q[`APSG_SYNC_W-1] : filt_q;
			end
			always_ff @(posedge mclk_i)
			begin
				if (srst_i)
				begin
					sync_q <= '0;
					filt_q <= `APSG_BIT_RST;
				end
				else
				begin
					sync_q <= sync_d;
					filt_q <= filt_d;
				end
			end
			assign pin_filt[gi] = filt_q;
		end
	endgenerate

	// Register writes; a reserved code is stored but drives nothing.
	always_comb
	begin
		sel_d = sel_q;
		gpo_d = gpo_q;
		rpt_d = rpt_q;
		rsv_d = rsv_q;
		sda_mode_d = sda_mode_q;
		sda_val_d = sda_val_q;
		if (reg_wr_i && reg_addr_i == `APSG_ADDR_AUX2)
		begin
			sel_d = apsg_sel_t'(reg_wdata_i[`APSG_SEL_MSB:`APSG_SEL_LSB]);
			gpo_d = reg_wdata_i[`APSG_GPO_BIT];
			rpt_d = reg_wdata_i[`APSG_RPT_BIT];
			rsv_d = reg_wdata_i[`APSG_RSV_BIT];
		end
		if (reg_wr_i && reg_addr_i == `APSG_ADDR_EXTA)
		begin
			sda_mode_d = apsg_sda_t'(reg_wdata_i[`APSG_SDA_MSB:`APSG_SDA_LSB]);
			sda_val_d = reg_wdata_i[`APSG_SDA_OUT_BIT];
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			sel_q <= apsg_sel_t'(`APSG_SEL_RST);
			gpo_q <= `APSG_BIT_RST;
			rpt_q <= `APSG_BIT_RST;
			rsv_q <= `APSG_BIT_RST;
			sda_mode_q <= apsg_sda_t'(`APSG_SDA_RST);
			sda_val_q <= `APSG_BIT_RST;
		end
		else
		begin
			sel_q <= sel_d;
			gpo_q <= gpo_d;
			rpt_q <= rpt_d;
			rsv_q <= rsv_d;
			sda_mode_q <= sda_mode_d;
			sda_val_q <= sda_val_d;
		end
	end

	// Interrupt source combination for the selected code.
	always_comb
	begin
		unique case (sel_q)
			SEL_HS_IRQ: irq_now = irq_headset_i;
			SEL_HS_BTN: irq_now = irq_headset_i | irq_button_i;
			SEL_ALL: irq_now = irq_headset_i | irq_button_i | irq_short_i | irq_agc_i;
			SEL_SC_AGC: irq_now = irq_short_i | irq_agc_i;
			SEL_HS_BTN_SC: irq_now = irq_headset_i | irq_button_i | irq_short_i;
			SEL_SC: irq_now = irq_short_i;
			SEL_AGC: irq_now = irq_agc_i;
			SEL_BTN: irq_now = irq_button_i;
			default: irq_now = 1'b0;
		endcase
	end

	// Only the rising edge of the combined source starts a pulse, so a held source fires once.
	assign irq_trig = irq_now & ~irq_prev_q;
	assign pulse_len = (sel_q == SEL_HS_IRQ) ? `APSG_CNT_W'(HS_PULSE_CYC) : `APSG_CNT_W'(PULSE_CYC);

	apsg_pulse_gen apsg_pulse_gen_i
	(
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.trig_i(irq_trig),
		.rpt_en_i(rpt_q),
		.stop_i(irq_flags_read_i),
		.len_i(pulse_len),
		.pulse_o(pulse)
	);

	assign aux_gpi = (sel_q == SEL_GPI) ? pin_filt[`APSG_PIN_AUX] : 1'b0;
	assign sda_gpi = (pin_filt[`APSG_PIN_SEL] && sda_mode_q == SDA_GPI) ? pin_filt[`APSG_PIN_SDA] : 1'b0;
	// The SDA driver can only pull low, so a one in the output bit just releases the pin.
	assign sda_drive_low = pin_filt[`APSG_PIN_SEL] && sda_mode_q == SDA_GPO && !sda_val_q;

	// Pin drive, serial clock and microphone sampling.
	always_comb
	begin
		aux_out_d = 1'b0;
		aux_oe_d = 1'b0;
		bclk_in_d = 1'b0;
		dmic_valid_d = 1'b0;
		dmic_data_d = dmic_data_q;
		unique case (sel_q)
			SEL_GPO:
			begin
				aux_oe_d = 1'b1;
				aux_out_d = gpo_q;
			end
			SEL_DMIC_A, SEL_DMIC_B, SEL_DMIC_C:
				if (dmic_clk_i != dmic_clk_q)
				begin
					dmic_valid_d = 1'b1;
					dmic_data_d = pin_filt[`APSG_PIN_AUX];
				end
			SEL_BCLK:
			begin
				aux_oe_d = bclk_master_i;
				aux_out_d = bclk_master_i & bclk_out_i;
				bclk_in_d = bclk_master_i ? 1'b0 : pin_filt[`APSG_PIN_AUX];
			end
			SEL_HS_IRQ, SEL_HS_BTN, SEL_ALL, SEL_SC_AGC, SEL_HS_BTN_SC, SEL_SC, SEL_AGC, SEL_BTN:
			begin
				aux_oe_d = 1'b1;
				aux_out_d = pulse;
			end
			default:
				aux_oe_d = 1'b0;
		endcase
		sda_oe_d = sda_drive_low;
	end

	// Register reads; the answer holds until the next read strobe.
	always_comb
	begin
		rdata_d = rdata_q;
		if (reg_rd_i)
		begin
			rdata_d = `APSG_RDATA_RST;
			if (reg_addr_i == `APSG_ADDR_AUX2)
			begin
				rdata_d[`APSG_SEL_MSB:`APSG_SEL_LSB] = sel_q;
				rdata_d[`APSG_GPO_BIT] = gpo_q;
				rdata_d[`APSG_GPI_BIT] = aux_gpi;
				rdata_d[`APSG_RPT_BIT] = rpt_q;
				rdata_d[`APSG_RSV_BIT] = rsv_q;
			end
			else if (reg_addr_i == `APSG_ADDR_EXTA)
			begin
				rdata_d[`APSG_SDA_MSB:`APSG_SDA_LSB] = sda_mode_q;
				rdata_d[`APSG_SDA_OUT_BIT] = sda_val_q;
				rdata_d[`APSG_SDA_IN_BIT] = sda_gpi;
			end
		end
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			irq_prev_q <= `APSG_BIT_RST;
			aux_out_q <= `APSG_BIT_RST;
			aux_oe_q <= `APSG_BIT_RST;
			sda_oe_q <= `APSG_BIT_RST;
			bclk_in_q <= `APSG_BIT_RST;
			dmic_clk_q <= `APSG_BIT_RST;
			dmic_data_q <= `APSG_BIT_RST;
			dmic_valid_q <= `APSG_BIT_RST;
			rdata_q <= `APSG_RDATA_RST;
		end
		else
		begin
			irq_prev_q <= irq_now;
			aux_out_q <= aux_out_d;
			aux_oe_q <= aux_oe_d;
			sda_oe_q <= sda_oe_d;
			bclk_in_q <= bclk_in_d;
			dmic_clk_q <= dmic_clk_i;
			dmic_data_q <= dmic_data_d;
			dmic_valid_q <= dmic_valid_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign aux_pin_two_out_o = aux_out_q;
	assign aux_pin_two_oe_o = aux_oe_q;
	assign sda_oe_o = sda_oe_q;
	assign sda_out_o = 1'b0;
	assign bclk_in_o = bclk_in_q;
	assign dmic_data_o = dmic_data_q;
	assign dmic_valid_o = dmic_valid_q;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	sequence dmic_edge_s;
		(sel_q inside {SEL_DMIC_A, SEL_DMIC_B, SEL_DMIC_C}) && (dmic_clk_i != dmic_clk_q);
	endsequence

	sequence irq_rise_s;
		(sel_q == SEL_SC) ##0 $rose(irq_short_i) ##1 (sel_q == SEL_SC);
	endsequence

	sel_reset_a: assert property (@(posedge mclk_i) disable iff (1'b0)
		srst_i |=> sel_q == SEL_OFF ##1 (!aux_pin_two_oe_o || sel_q != SEL_OFF))
		else $error("Selector did not return to disabled after reset.");

	pin_undriven_a: assert property ((sel_q == SEL_OFF || sel_q == SEL_RSV) |=> !aux_pin_two_oe_o)
		else $error("Auxiliary pin driven while disabled or reserved.");

	gpo_drive_a: assert property ((sel_q == SEL_GPO) |=> aux_pin_two_oe_o && aux_pin_two_out_o == $past(gpo_q))
		else $error("Output mode does not drive the stored output bit.");

	input_filter_a: assert property (($stable(aux_pin_two_in_i) ##1 $stable(aux_pin_two_in_i))
		|-> ##3 g_sync[`APSG_PIN_AUX].filt_q == $past(aux_pin_two_in_i, 4))
		else $error("Pin input level not taken after settling.");

	dmic_sample_a: assert property (dmic_edge_s |=> dmic_valid_o && dmic_data_o == $past(pin_filt[`APSG_PIN_AUX]))
		else $error("Microphone data not sampled on a modulator clock edge.");

	bclk_dir_a: assert property ((sel_q == SEL_BCLK) |=> aux_pin_two_oe_o == $past(bclk_master_i))
		else $error("Bit clock pin direction does not follow the master setting.");

	irq_route_a: assert property (irq_rise_s |=> aux_pin_two_oe_o && aux_pin_two_out_o)
		else $error("Short-circuit event did not reach the auxiliary pin.");

	sda_gate_a: assert property (!pin_filt[`APSG_PIN_SEL] |=> !sda_oe_o)
		else $error("SDA driven while not in SPI mode.");

	sda_release_a: assert property ((pin_filt[`APSG_PIN_SEL] && sda_mode_q == SDA_GPO) |=> sda_oe_o == !$past(sda_val_q))
		else $error("SDA output level does not follow its control bit.");

	sda_status_a: assert property ((reg_rd_i && reg_addr_i == `APSG_ADDR_EXTA && !pin_filt[`APSG_PIN_SEL])
		|=> !reg_rdata_o[`APSG_SDA_IN_BIT])
		else $error("SDA input status visible outside SPI mode.");

endmodule

// ===== logic/apsg_pulse_gen.sv
// Interrupt pulse generator: one pulse per event, or repeating pulses until the flags are read.
// Assumes trigger and stop are one-cycle pulses on mclk_i and len_i is at least one.
`timescale 1ns/10ps
`include "apsg_regs.svh"

module apsg_pulse_gen
(
	input wire logic mclk_i,
	input wire logic srst_i,
	input wire logic trig_i,
	input wire logic rpt_en_i,
	input wire logic stop_i,
	input wire logic [`APSG_CNT_W-1:0] len_i,
	output logic pulse_o
);
	import apsg_pkg::*;

	apsg_pst_t st_q, st_d;
	logic [`APSG_CNT_W-1:0] cnt_q, cnt_d;
	logic rep_q, rep_d;
	logic [`APSG_CNT_W-1:0] hi_len_q;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		rep_d = rep_q;
		if (stop_i)
			rep_d = 1'b0;
		// A new event beside a flags read keeps the repetition alive.
		if (trig_i && rpt_en_i)
			rep_d = 1'b1;
		unique case (st_q)
			PST_IDLE:
				if (trig_i)
				begin
					st_d = PST_HIGH;
					cnt_d = len_i - 1'b1;
				end
			PST_HIGH:
				if (cnt_q == '0)
				begin
					st_d = rep_d ? PST_LOW : PST_IDLE;
					cnt_d = len_i - 1'b1;
				end
				else
					cnt_d = cnt_q - 1'b1;
			PST_LOW:
				if (cnt_q == '0)
				begin
					st_d = rep_d ? PST_HIGH : PST_IDLE;
					cnt_d = len_i - 1'b1;
				end
				else
					cnt_d = cnt_q - 1'b1;
			default:
				st_d = PST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i)
	begin
		if (srst_i)
		begin
			st_q <= PST_IDLE;
			cnt_q <= '0;
			rep_q <= `APSG_BIT_RST;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			rep_q <= rep_d;
		end
	end

	assign pulse_o = (st_q == PST_HIGH);

	always_ff @(posedge mclk_i)
	begin
		if (srst_i || st_q != PST_HIGH)
			hi_len_q <= '0;
		else
			hi_len_q <= hi_len_q + 1'b1;
	end

	pulse_width_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(st_q == PST_HIGH && cnt_q == '0) |-> hi_len_q == len_i - 1'b1)
		else $error("Interrupt pulse width differs from the programmed length.");

	pulse_start_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(st_q == PST_IDLE && trig_i) |=> pulse_o ##1 (pulse_o || len_i == 1'b1))
		else $error("Interrupt pulse did not start after an event.");

	repeat_stop_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(stop_i && !trig_i && st_q != PST_IDLE && cnt_q == '0) |=> st_q == PST_IDLE)
		else $error("Repeating pulses continued after the flags were read.");

endmodule

// ===== tb/apsg_pin_model.sv
// Pin-side partner of the auxiliary pin and SDA block: resolves both wires for the bench.
// Assumes the bench supplies the external drivers; runs on the core clock.
`timescale 1ns/10ps

module apsg_pin_model
(
	input wire logic mclk_i,
	input wire logic aux_oe_i,
	input wire logic aux_out_i,
	input wire logic ext_oe_i,
	input wire logic ext_val_i,
	input wire logic sda_oe_i,
	input wire logic sda_ext_low_i,
	output logic aux_lvl_o,
	output logic sda_lvl_o
);
	logic float_q = 1'b0;

	// The auxiliary pin has no keeper, so a floating pin wanders instead of holding its last value.
	always_ff @(posedge mclk_i)
	begin
		float_q <= ~float_q;
	end

	assign aux_lvl_o = aux_oe_i ? aux_out_i : (ext_oe_i ? ext_val_i : float_q);
	// Open-drain wire with an external pull-up: high unless some party pulls it down.
	assign sda_lvl_o = ~(sda_oe_i | sda_ext_low_i);
endmodule

// ===== tb/aux_pin_and_sda_gpio_control_bench.sv
// Self-checking bench of the auxiliary pin and SDA control block.
// Assumes apsg_ctrl with short pulse counts and apsg_pin_model standing on the pins.
`timescale 1ns/10ps
`include "apsg_regs.svh"

module aux_pin_and_sda_gpio_control_bench;
	logic mclk_i, srst_i, reg_wr_i, reg_rd_i, irq_flags_read_i, dmic_clk_i, bclk_master_i, bclk_out_i;
	logic spi_mode_i, bclk_in_o, dmic_data_o, dmic_valid_o, aux_in, aux_out, aux_oe, sda_in, sda_out, sda_oe;
	logic ext_oe, ext_val, sda_ext_low;
	logic [6:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o;
	logic [3:0] irq_src;
	logic [15:0] tbl [15];
	int error_cnt = 0;
	int tests_run = 0;
	int vcnt = 0;
	int n, rises;
	logic prev;

	apsg_ctrl #(.PULSE_CYC(20), .HS_PULSE_CYC(15)) apsg_ctrl_i
	(
		.mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .spi_mode_i(spi_mode_i),
		.irq_headset_i(irq_src[3]), .irq_button_i(irq_src[2]), .irq_short_i(irq_src[1]), .irq_agc_i(irq_src[0]),
		.irq_flags_read_i(irq_flags_read_i), .dmic_clk_i(dmic_clk_i), .bclk_master_i(bclk_master_i),
		.bclk_out_i(bclk_out_i), .bclk_in_o(bclk_in_o), .dmic_data_o(dmic_data_o), .dmic_valid_o(dmic_valid_o),
		.aux_pin_two_in_i(aux_in), .aux_pin_two_out_o(aux_out), .aux_pin_two_oe_o(aux_oe),
		.sda_in_i(sda_in), .sda_out_o(sda_out), .sda_oe_o(sda_oe)
	);

	apsg_pin_model apsg_pin_model_i
	(
		.mclk_i(mclk_i), .aux_oe_i(aux_oe), .aux_out_i(aux_out), .ext_oe_i(ext_oe), .ext_val_i(ext_val),
		.sda_oe_i(sda_oe), .sda_ext_low_i(sda_ext_low), .aux_lvl_o(aux_in), .sda_lvl_o(sda_in)
	);

	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i)
		if (dmic_valid_o === 1'b1)
			vcnt = vcnt + 1;

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge mclk_i);
		#1;
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
	endtask

	// Counts the cycles the pin drives high after one source pulse; 40 cycles outlast any single pulse.
	task automatic irq_case(input logic [15:0] row);
		n = 0;
		wr(`APSG_ADDR_AUX2, {row[15:12], 4'h0});
		cyc(3);
		@(posedge mclk_i);
		irq_src <= row[11:8];
		@(posedge mclk_i);
		irq_src <= 4'h0;
		repeat (40)
		begin
			@(posedge mclk_i);
			#1;
			if (aux_out === 1'b1 && aux_oe === 1'b1)
				n++;
		end
		chk(n[7:0], row[7:0]);
	endtask

	initial
	begin
		#200000;
		error_cnt++;
		results();
	end

	initial
	begin
		{srst_i, reg_wr_i, reg_rd_i, irq_flags_read_i, dmic_clk_i, bclk_master_i, bclk_out_i} = 7'h40;
		{spi_mode_i, ext_oe, ext_val, sda_ext_low} = 4'h0;
		reg_addr_i = 7'h00;
		reg_wdata_i = 8'h00;
		irq_src = 4'h0;
		// Rows: selector, sources fired (headset, button, short, noise), expected high cycles.
		tbl = '{16'h280F, 16'h2400, 16'h9414, 16'h9200, 16'hA114, 16'hA814, 16'hB214, 16'hB400,
			16'hC214, 16'hD214, 16'hD100, 16'hE114, 16'hF414, 16'h0800, 16'h1800};
		repeat (3) @(posedge mclk_i);
		srst_i <= 1'b0;
		#1;
		chk({aux_oe, sda_oe}, 2'b00);
		rd(`APSG_ADDR_AUX2, 8'h00);
		rd(`APSG_ADDR_EXTA, 8'h00);
		rd(7'h65, 8'h00);
		wr(`APSG_ADDR_AUX2, 8'h48);
		cyc(2);
		chk({aux_oe, aux_out}, 2'b11);
		rd(`APSG_ADDR_AUX2, 8'h48);
		wr(`APSG_ADDR_AUX2, 8'h40);
		cyc(2);
		chk({aux_oe, aux_out}, 2'b10);
		wr(`APSG_ADDR_AUX2, 8'h10);
		cyc(2);
		chk(aux_oe, 1'b0);
		wr(`APSG_ADDR_AUX2, 8'h30);
		ext_oe <= 1'b1;
		ext_val <= 1'b1;
		cyc(6);
		chk(aux_oe, 1'b0);
		rd(`APSG_ADDR_AUX2, 8'h34);
		@(posedge mclk_i);
		ext_val <= 1'b0;
		wr(`APSG_ADDR_AUX2, 8'h34);
		cyc(5);
		rd(`APSG_ADDR_AUX2, 8'h30);
		for (int s = 5; s < 8; s++)
		begin
			wr(`APSG_ADDR_AUX2, {s[3:0], 4'h0});
			ext_val <= s[0];
			cyc(6);
			vcnt = 0;
			@(posedge mclk_i);
			dmic_clk_i <= 1'b1;
			cyc(5);
			@(posedge mclk_i);
			dmic_clk_i <= 1'b0;
			cyc(5);
			chk(vcnt[7:0], 8'h02);
			chk({aux_oe, dmic_data_o}, {1'b0, s[0]});
		end
		wr(`APSG_ADDR_AUX2, 8'h80);
		ext_oe <= 1'b0;
		bclk_master_i <= 1'b1;
		bclk_out_i <= 1'b1;
		cyc(3);
		chk({aux_oe, aux_out}, 2'b11);
		@(posedge mclk_i);
		bclk_out_i <= 1'b0;
		cyc(2);
		chk({aux_oe, aux_out}, 2'b10);
		@(posedge mclk_i);
		bclk_master_i <= 1'b0;
		ext_oe <= 1'b1;
		ext_val <= 1'b1;
		cyc(6);
		chk({aux_oe, bclk_in_o}, 2'b01);
		@(posedge mclk_i);
		ext_oe <= 1'b0;
		for (int i = 0; i < 15; i++)
			irq_case(tbl[i]);
		wr(`APSG_ADDR_AUX2, 8'hD2);
		cyc(3);
		@(posedge mclk_i);
		irq_src <= 4'h2;
		@(posedge mclk_i);
		irq_src <= 4'h0;
		rises = 0;
		prev = 1'b0;
		repeat (90)
		begin
			@(posedge mclk_i);
			#1;
			if (aux_out === 1'b1 && prev !== 1'b1)
				rises++;
			prev = aux_out;
		end
		chk(rises[7:0], 8'h03);
		// The flags read lands on the last cycle of the third high phase, so the stop meets a phase end.
		repeat (9) @(posedge mclk_i);
		irq_flags_read_i <= 1'b1;
		@(posedge mclk_i);
		irq_flags_read_i <= 1'b0;
		cyc(45);
		n = 0;
		repeat (60)
		begin
			@(posedge mclk_i);
			#1;
			if (aux_out !== 1'b0)
				n++;
		end
		chk(n[7:0], 8'h00);
		@(posedge mclk_i);
		spi_mode_i <= 1'b1;
		cyc(5);
		wr(`APSG_ADDR_EXTA, 8'h80);
		cyc(2);
		chk({sda_oe, sda_in, sda_out}, 3'b100);
		wr(`APSG_ADDR_EXTA, 8'hA0);
		cyc(2);
		chk({sda_oe, sda_in}, 2'b01);
		rd(`APSG_ADDR_EXTA, 8'hA0);
		wr(`APSG_ADDR_EXTA, 8'h40);
		sda_ext_low <= 1'b1;
		cyc(5);
		rd(`APSG_ADDR_EXTA, 8'h40);
		@(posedge mclk_i);
		sda_ext_low <= 1'b0;
		cyc(5);
		rd(`APSG_ADDR_EXTA, 8'h50);
		wr(`APSG_ADDR_EXTA, 8'h8F);
		rd(`APSG_ADDR_EXTA, 8'h80);
		wr(`APSG_ADDR_EXTA, 8'hC0);
		cyc(2);
		chk(sda_oe, 1'b0);
		@(posedge mclk_i);
		spi_mode_i <= 1'b0;
		wr(`APSG_ADDR_EXTA, 8'h80);
		cyc(6);
		chk(sda_oe, 1'b0);
		wr(`APSG_ADDR_EXTA, 8'h40);
		cyc(5);
		rd(`APSG_ADDR_EXTA, 8'h40);
		results();
	end
endmodule
